/* design/ucr_channel_regs.sv */
// register file and address decode for one serial channel
`timescale 1ns/10ps
module ucr_channel_regs (
   // clock, reset, enable
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   // host parallel bus
   input  wire logic                   host_cs,
   input  wire logic [2:0]             host_addr,
   input  wire logic                   host_rd,
   input  wire logic                   host_wr,
   input  wire logic [7:0]             host_wdata,
   output      logic [7:0]             host_rdata,
   // receiver side
   input  wire logic [7:0]             rx_char,
   output      logic                   rx_pop,
   // transmitter side
   output      logic [7:0]             tx_char,
   output      logic                   tx_push,
   // status from the other channel blocks
   input  wire logic [3:0]             int_source,
   input  wire logic                   int_xoff_seen,
   input  wire logic                   int_rts_cts,
   input  wire logic [7:0]             line_status_in,
   input  wire logic [3:0]             modem_delta,
   input  wire logic [3:0]             modem_level,
   output      logic                   modem_status_read,
   // fifo control
   output      logic                   fifo_enable,
   output      logic                   rx_fifo_clr,
   output      logic                   tx_fifo_clr,
   output      logic                   dma_mode,
   output      logic [1:0]             tx_trigger,
   output      logic [1:0]             rx_trigger,
   // interrupt enables as seen by the interrupt block
   output      logic [7:0]             int_enable,
   // line format
   output      logic [1:0]             word_length,
   output      logic                   stop_bits,
   output      logic [2:0]             parity_ctl,
   output      logic                   tx_break,
   // baud generator
   output      logic [15:0]            baud_divisor,
   output      logic [3:0]             baud_fraction,
   output      logic                   sample_8x,
   output      logic                   sample_4x,
   output      logic                   baud_prescale_select,
   // modem control outputs, rts_n and dtr_n pins active low
   output      logic                   rts_n,
   output      logic                   dtr_n,
   output      logic                   irq_output_gate,
   output      logic                   spare_output,
   output      logic                   loopback,
   output      logic                   resume_any,
   output      logic                   infrared_mode,
   // flow control setup
   output      logic [3:0]             soft_flow_mode,
   output      logic                   special_char_en,
   output      logic                   auto_rts_en,
   output      logic                   auto_cts_en,
   output      logic [7:0]             resume_char_1,
   output      logic [7:0]             resume_char_2,
   output      logic [7:0]             stop_char_1,
   output      logic [7:0]             stop_char_2
);
   import ucr_pkg::*;

   ucr_state_t st_r;
   ucr_state_t st_nxt;
   ucr_map_t   map_sel;
   logic       gate;
   logic       rd_req;
   logic       wr_req;
   logic [7:0] width_mask;
   logic [3:0][7:0] chars_raw;
   logic [3:0][7:0] chars_cmp;

   // which map the current control value selects
   function automatic ucr_map_t map_of(input logic [7:0] ctl);
      if (ctl == UCR_ENH_KEY) begin
         return UCR_MAP_ENHANCED;
      end else if (ctl[UCR_LC_DIV_BIT]) begin
         return UCR_MAP_DIVISOR;
      end
      return UCR_MAP_NORMAL;
   endfunction

   // clears the unlockable bits of a value while the gate is shut
   function automatic logic [7:0] ext_gate(input logic [7:0] v,
                                           input logic [7:0] ext,
                                           input logic       en);
      return en ? v : (v & ~ext);
   endfunction

   // merges a host write into a register, unlockable bits held while shut
   function automatic logic [7:0] ext_write(input logic [7:0] old,
                                            input logic [7:0] wd,
                                            input logic [7:0] ext,
                                            input logic       en);
      return en ? wd : ((wd & ~ext) | (old & ext));
   endfunction

   // mask of the significant character bits from the word length field
   function automatic logic [7:0] char_mask(input logic [1:0] wl);
      logic [7:0] m;
      m = 8'hFF;
      unique case (wl)
         2'b00: m = 8'h1F;
         2'b01: m = 8'h3F;
         2'b10: m = 8'h7F;
         2'b11: m = 8'hFF;
      endcase
      return m;
   endfunction

   // decode is purely combinational on the live control and gate values
   assign map_sel = map_of(st_r.line_control);
   assign gate    = st_r.enhanced_function[UCR_EF_GATE_BIT];
   // chip select qualifies every access to this channel's set
   assign rd_req  = ce & host_cs & host_rd;
   assign wr_req  = ce & host_cs & host_wr;

   // side effects of reads, combinational so they meet the read cycle
   always_comb begin
      rx_pop            = 1'b0;
      modem_status_read = 1'b0;
      if (rd_req && map_sel != UCR_MAP_DIVISOR && host_addr == UCR_OFS_DATA) begin
         rx_pop = 1'b1;
      end
      if (rd_req && map_sel != UCR_MAP_ENHANCED && host_addr == UCR_OFS_MODEM_ST) begin
         modem_status_read = 1'b1;
      end
   end

   // next state: read mux, write decode, self-clearing pulses
   always_comb begin
      st_nxt             = st_r;
      st_nxt.tx_push     = 1'b0;
      st_nxt.rx_fifo_clr = 1'b0;
      st_nxt.tx_fifo_clr = 1'b0;

      // read path, data held until the next read
      if (rd_req) begin
         unique case (host_addr)
            UCR_OFS_DATA: begin
               if (map_sel == UCR_MAP_DIVISOR) begin
                  st_nxt.rd_data = st_r.baud_divisor_low;
               end else begin
                  st_nxt.rd_data = rx_char;
               end
            end
            UCR_OFS_MASK: begin
               if (map_sel == UCR_MAP_DIVISOR) begin
                  st_nxt.rd_data = st_r.baud_divisor_high;
               end else begin
                  st_nxt.rd_data = ext_gate(st_r.interrupt_mask, UCR_EXT_MASK, gate);
               end
            end
            UCR_OFS_STAT_CTL: begin
               unique case (map_sel)
                  UCR_MAP_ENHANCED: st_nxt.rd_data = st_r.enhanced_function;
                  UCR_MAP_DIVISOR: begin
                     // fraction only visible through the gate
                     st_nxt.rd_data = gate ?
                        (st_r.baud_divisor_fraction & UCR_FRAC_USED) : 8'h00;
                  end
                  UCR_MAP_NORMAL: begin
                     st_nxt.rd_data = {{2{st_r.fifo_control[UCR_FC_ENABLE_BIT]}},
                                       gate & int_rts_cts,
                                       gate & int_xoff_seen,
                                       int_source};
                  end
               endcase
            end
            UCR_OFS_LINE_CTL: st_nxt.rd_data = st_r.line_control;
            UCR_OFS_MODEM_CTL: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.rd_data = st_r.flow_resume_char_1;
               end else begin
                  st_nxt.rd_data = ext_gate(st_r.modem_control, UCR_EXT_MODEM, gate);
               end
            end
            UCR_OFS_LINE_STAT: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.rd_data = st_r.flow_resume_char_2;
               end else begin
                  st_nxt.rd_data = line_status_in;
               end
            end
            UCR_OFS_MODEM_ST: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.rd_data = st_r.flow_stop_char_1;
               end else begin
                  st_nxt.rd_data = {modem_level, modem_delta};
               end
            end
            UCR_OFS_SCRATCH: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.rd_data = st_r.flow_stop_char_2;
               end else begin
                  st_nxt.rd_data = st_r.scratch_pad;
               end
            end
         endcase
      end

      // write path; status registers ignore writes
      if (wr_req) begin
         unique case (host_addr)
            UCR_OFS_DATA: begin
               if (map_sel == UCR_MAP_DIVISOR) begin
                  st_nxt.baud_divisor_low = host_wdata;
               end else begin
                  st_nxt.tx_char = host_wdata;
                  st_nxt.tx_push = 1'b1;
               end
            end
            UCR_OFS_MASK: begin
               if (map_sel == UCR_MAP_DIVISOR) begin
                  st_nxt.baud_divisor_high = host_wdata;
               end else begin
                  st_nxt.interrupt_mask =
                     ext_write(st_r.interrupt_mask, host_wdata, UCR_EXT_MASK, gate);
               end
            end
            UCR_OFS_STAT_CTL: begin
               unique case (map_sel)
                  UCR_MAP_ENHANCED: st_nxt.enhanced_function = host_wdata;
                  UCR_MAP_DIVISOR: begin
                     // a shut gate leaves the fraction untouched
                     if (gate) begin
                        st_nxt.baud_divisor_fraction = host_wdata & UCR_FRAC_USED;
                     end
                  end
                  UCR_MAP_NORMAL: begin
                     // clear bits become pulses and are not stored
                     st_nxt.fifo_control = ext_write(st_r.fifo_control,
                        host_wdata & UCR_FC_KEEP, UCR_EXT_FIFO, gate);
                     st_nxt.rx_fifo_clr = host_wdata[UCR_FC_RXCLR_BIT];
                     st_nxt.tx_fifo_clr = host_wdata[UCR_FC_TXCLR_BIT];
                  end
               endcase
            end
            UCR_OFS_LINE_CTL: st_nxt.line_control = host_wdata;
            UCR_OFS_MODEM_CTL: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.flow_resume_char_1 = host_wdata;
               end else begin
                  // reserved bit 2 kept at zero
                  st_nxt.modem_control = ext_write(st_r.modem_control,
                     host_wdata & UCR_MC_WR_MASK, UCR_EXT_MODEM, gate);
               end
            end
            UCR_OFS_LINE_STAT: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.flow_resume_char_2 = host_wdata;
               end
            end
            UCR_OFS_MODEM_ST: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.flow_stop_char_1 = host_wdata;
               end
            end
            UCR_OFS_SCRATCH: begin
               if (map_sel == UCR_MAP_ENHANCED) begin
                  st_nxt.flow_stop_char_2 = host_wdata;
               end else begin
                  st_nxt.scratch_pad = host_wdata;
               end
            end
         endcase
      end
   end

   // one register for all state; low enable freezes everything
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_r <= '{default: '0};
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // flow characters compared only over the programmed width
   assign width_mask   = char_mask(st_r.line_control[1:0]);
   assign chars_raw[0] = st_r.flow_resume_char_1;
   assign chars_raw[1] = st_r.flow_resume_char_2;
   assign chars_raw[2] = st_r.flow_stop_char_1;
   assign chars_raw[3] = st_r.flow_stop_char_2;
   for (genvar i = 0; i < 4; i++) begin : g_char
      assign chars_cmp[i] = chars_raw[i] & width_mask;
   end
   assign resume_char_1 = chars_cmp[0];
   assign resume_char_2 = chars_cmp[1];
   assign stop_char_1   = chars_cmp[2];
   assign stop_char_2   = chars_cmp[3];

   // host and data path outputs
   assign host_rdata  = st_r.rd_data;
   assign tx_char     = st_r.tx_char;
   assign tx_push     = st_r.tx_push;
   assign rx_fifo_clr = st_r.rx_fifo_clr;
   assign tx_fifo_clr = st_r.tx_fifo_clr;

   // fifo and interrupt settings, unlockable parts masked by the gate
   assign fifo_enable = st_r.fifo_control[UCR_FC_ENABLE_BIT];
   assign dma_mode    = st_r.fifo_control[3];
   assign tx_trigger  = gate ? st_r.fifo_control[5:4] : 2'b00;
   assign rx_trigger  = st_r.fifo_control[7:6];
   assign int_enable  = ext_gate(st_r.interrupt_mask, UCR_EXT_MASK, gate);

   // line format straight from line control
   assign word_length = st_r.line_control[1:0];
   assign stop_bits   = st_r.line_control[UCR_LC_STOP_BIT];
   assign parity_ctl  = st_r.line_control[5:3];
   assign tx_break    = st_r.line_control[UCR_LC_BREAK_BIT];

   // baud generator; fraction and sample selects need the gate
   assign baud_divisor  = {st_r.baud_divisor_high, st_r.baud_divisor_low};
   assign baud_fraction = gate ? st_r.baud_divisor_fraction[3:0] : 4'h0;
   assign sample_8x     = gate & st_r.baud_divisor_fraction[UCR_FR_8X_BIT];
   assign sample_4x     = gate & st_r.baud_divisor_fraction[UCR_FR_4X_BIT];

   // modem control; rts_n and dtr_n are active low so a set bit drives them low, the other outputs follow their bits, bits 5 to 7 only with the gate open
   assign rts_n                = ~st_r.modem_control[UCR_MC_RTS_BIT];
   assign dtr_n                = ~st_r.modem_control[UCR_MC_DTR_BIT];
   assign irq_output_gate      = st_r.modem_control[UCR_MC_IRQGATE_BIT];
   assign spare_output         = st_r.modem_control[UCR_MC_SPARE_BIT];
   assign loopback             = st_r.modem_control[UCR_MC_LOOP_BIT];
   assign resume_any           = gate & st_r.modem_control[UCR_MC_ANYRES_BIT];
   assign infrared_mode        = gate & st_r.modem_control[UCR_MC_IR_BIT];
   assign baud_prescale_select = gate & st_r.modem_control[UCR_MC_PRESC_BIT];

   // enhanced function fields
   assign soft_flow_mode  = st_r.enhanced_function[3:0];
   assign special_char_en = st_r.enhanced_function[5];
   assign auto_rts_en     = st_r.enhanced_function[6];
   assign auto_cts_en     = st_r.enhanced_function[7];

endmodule // ucr_channel_regs

/* design/ucr_pkg.sv */
// constants, field layout and state type of the channel register decoder
// Notes on behaviour
// - each channel has its own register set; three address lines pick a register
// - offset 0 normal map: read oldest received byte, write queues byte to transmit
// - offset 2 normal map: read interrupt status, write FIFO control fields
// - offset 1 normal map holds the interrupt mask, low and extended enables
// - divisor bit set and control not 0xBF: offsets 0,1 hold divisor bytes
// - divisor map offset 2 holds fraction and sampling selects, needs the gate bit
// - control value 0xBF puts the enhanced function register at offset 2
// - control value 0xBF puts the two resume characters at offsets 4 and 5
// - control value 0xBF puts the two stop characters at offsets 6 and 7
// - extended fields act only while enhanced bit 4 is set, else read zero
// - line control sits at offset 3 in every map with its documented fields
// - modem control drives interrupt gate, request-to-send, terminal-ready and mode bits
// - line status at offset 5 reports receive, error and transmit-empty flags
// - modem status at offset 6 reports change flags and input states
// - offset 7 normal map is a plain scratch byte
// - low two control bits pick 5 to 8 bit characters and compare width
package ucr_pkg;

   // register offsets on the three address lines
   localparam logic [2:0] UCR_OFS_DATA      = 3'h0;
   localparam logic [2:0] UCR_OFS_MASK      = 3'h1;
   localparam logic [2:0] UCR_OFS_STAT_CTL  = 3'h2;
   localparam logic [2:0] UCR_OFS_LINE_CTL  = 3'h3;
   localparam logic [2:0] UCR_OFS_MODEM_CTL = 3'h4;
   localparam logic [2:0] UCR_OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] UCR_OFS_MODEM_ST  = 3'h6;
   localparam logic [2:0] UCR_OFS_SCRATCH   = 3'h7;

   // control value that opens the enhanced map
   localparam logic [7:0] UCR_ENH_KEY       = 8'hBF;

   // field positions
   localparam int UCR_LC_DIV_BIT     = 7;
   localparam int UCR_LC_BREAK_BIT   = 6;
   localparam int UCR_LC_STOP_BIT    = 2;
   localparam int UCR_EF_GATE_BIT    = 4;
   localparam int UCR_FC_ENABLE_BIT  = 0;
   localparam int UCR_FC_RXCLR_BIT   = 1;
   localparam int UCR_FC_TXCLR_BIT   = 2;
   localparam int UCR_MC_DTR_BIT     = 0;
   localparam int UCR_MC_RTS_BIT     = 1;
   localparam int UCR_MC_SPARE_BIT   = 2;
   localparam int UCR_MC_IRQGATE_BIT = 3;
   localparam int UCR_MC_LOOP_BIT    = 4;
   localparam int UCR_MC_ANYRES_BIT  = 5;
   localparam int UCR_MC_IR_BIT      = 6;
   localparam int UCR_MC_PRESC_BIT   = 7;
   localparam int UCR_FR_8X_BIT      = 4;
   localparam int UCR_FR_4X_BIT      = 5;

   // bits that only the gate bit unlocks, then the used-bit and write masks
   localparam logic [7:0] UCR_EXT_MASK   = 8'hF0;
   localparam logic [7:0] UCR_EXT_FIFO   = 8'h30;
   localparam logic [7:0] UCR_EXT_MODEM  = 8'hE0;
   localparam logic [7:0] UCR_FRAC_USED  = 8'h3F;
   localparam logic [7:0] UCR_MC_WR_MASK = 8'hFB;
   localparam logic [7:0] UCR_FC_KEEP    = 8'hF9;

   // values after reset
   localparam logic [7:0] UCR_RST_BYTE   = 8'h00;

   // register maps chosen by the line control value
   typedef enum logic [1:0] {UCR_MAP_NORMAL, UCR_MAP_DIVISOR, UCR_MAP_ENHANCED} ucr_map_t;

   // all state of the decoder
   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] interrupt_mask;
      logic [7:0] fifo_control;
      logic [7:0] enhanced_function;
      logic [7:0] modem_control;
      logic [7:0] scratch_pad;
      logic [7:0] baud_divisor_low;
      logic [7:0] baud_divisor_high;
      logic [7:0] baud_divisor_fraction;
      logic [7:0] flow_resume_char_1;
      logic [7:0] flow_resume_char_2;
      logic [7:0] flow_stop_char_1;
      logic [7:0] flow_stop_char_2;
      logic [7:0] rd_data;
      logic [7:0] tx_char;
      logic       tx_push;
      logic       rx_fifo_clr;
      logic       tx_fifo_clr;
   } ucr_state_t;

endpackage

/* tb/ucr_channel_regs_properties.sv */
// concurrent checks on the channel register decoder ports
`timescale 1ns/10ps
module ucr_channel_regs_properties (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic       ce,
   // host bus
   input wire logic       host_cs,
   input wire logic [2:0] host_addr,
   input wire logic       host_rd,
   input wire logic       host_wr,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   // channel side outputs
   input wire logic [7:0] tx_char,
   input wire logic       tx_push,
   input wire logic       rx_pop,
   input wire logic       rx_fifo_clr,
   input wire logic       modem_status_read,
   input wire logic       rts_n,
   input wire logic       dtr_n
);
   import ucr_pkg::*;
   logic       rd_tk, wr_tk, normal, data_map, data_wr;
   logic [7:0] lc_r, ef_r, sp_r;
   assign rd_tk = ce && host_cs && host_rd;
   assign wr_tk = ce && host_cs && host_wr;
   assign normal = !lc_r[UCR_LC_DIV_BIT];
   // the data port stays open in the enhanced map, only the divisor map takes it over
   assign data_map = normal || lc_r == UCR_ENH_KEY;
   assign data_wr = wr_tk && host_addr == UCR_OFS_DATA && data_map;
   // shadows rebuilt from host writes, so the map is known without peeking inside
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         lc_r <= 8'h00;
         ef_r <= 8'h00;
         sp_r <= 8'h00;
      end else begin
         if (wr_tk && host_addr == UCR_OFS_LINE_CTL) lc_r <= host_wdata;
         if (wr_tk && host_addr == UCR_OFS_STAT_CTL && lc_r == UCR_ENH_KEY) ef_r <= host_wdata;
         if (wr_tk && host_addr == UCR_OFS_SCRATCH && lc_r != UCR_ENH_KEY) sp_r <= host_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_enh_rd;
      rd_tk && host_addr == UCR_OFS_STAT_CTL && lc_r == UCR_ENH_KEY;
   endsequence
   tx_push_a: assert property (data_wr |=> tx_push && tx_char == $past(host_wdata))
      else $error("no transmit push after data write");
   push_cause_a: assert property (tx_push |-> $past(data_wr))
      else $error("transmit push without data write");
   rx_pop_a: assert property (rd_tk && host_addr == UCR_OFS_DATA && data_map |-> rx_pop)
      else $error("receive pop missing");
   pop_cause_a: assert property (rx_pop |->
      rd_tk && host_addr == UCR_OFS_DATA && data_map)
      else $error("receive pop outside data read");
   msr_read_a: assert property (modem_status_read ==
      (rd_tk && host_addr == UCR_OFS_MODEM_ST && lc_r != UCR_ENH_KEY))
      else $error("modem status read strobe wrong");
   fifo_clr_a: assert property (wr_tk && host_addr == UCR_OFS_STAT_CTL && normal
      && host_wdata[UCR_FC_RXCLR_BIT] |=> rx_fifo_clr ##1 !rx_fifo_clr)
      else $error("receive fifo clear pulse wrong");
   enh_read_a: assert property (s_enh_rd |=> host_rdata == $past(ef_r))
      else $error("enhanced function readback wrong");
   scratch_rd_a: assert property (rd_tk && host_addr == UCR_OFS_SCRATCH
      && lc_r != UCR_ENH_KEY |=> host_rdata == $past(sp_r))
      else $error("scratch readback wrong");
   line_rd_a: assert property (rd_tk && host_addr == UCR_OFS_LINE_CTL
      |=> host_rdata == $past(lc_r))
      else $error("line control readback wrong");
   rdata_hold_a: assert property (!rd_tk |=> $stable(host_rdata))
      else $error("read data moved without a read");
   modem_pin_a: assert property (wr_tk && host_addr == UCR_OFS_MODEM_CTL
      && lc_r != UCR_ENH_KEY
      |=> rts_n != $past(host_wdata[1]) && dtr_n != $past(host_wdata[0]))
      else $error("modem control pins wrong");
endmodule // ucr_channel_regs_properties

/* tb/ucr_host_model.sv */
// host processor model on the channel's parallel register bus
`timescale 1ns/10ps
module ucr_host_model (
   // clock
   input  wire logic       sys_clk,
   // bus toward the channel
   output      logic       host_cs,
   output      logic [2:0] host_addr,
   output      logic       host_rd,
   output      logic       host_wr,
   output      logic [7:0] host_wdata,
   input  wire logic [7:0] host_rdata
);
   initial begin
      host_cs = 1'b0;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_addr = 3'h0;
      host_wdata = 8'h00;
   end
   // one access: set after an edge, held over the taking edge, then dropped
   task automatic access(input logic [2:0] a, input logic [7:0] d, input logic w);
      @(posedge sys_clk);
      #1;
      host_cs = 1'b1;
      host_addr = a;
      host_wdata = d;
      host_wr = w;
      host_rd = !w;
      @(posedge sys_clk);
      #1;
      host_cs = 1'b0;
      host_rd = 1'b0;
      host_wr = 1'b0;
      // idle lines change so a stale value can never pass as valid
      host_addr = ~a;
      host_wdata = ~d;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      access(a, d, 1'b1);
   endtask
   // read data is registered on the taking edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      access(a, 8'h00, 1'b0);
      d = host_rdata;
   endtask
endmodule // ucr_host_model

/* tb/uart_channel_register_decode_test.sv */
// self-checking bench for the channel register decoder
`timescale 1ns/10ps
module uart_channel_register_decode_test;
   logic        sys_clk, reset, ce, host_cs, host_rd, host_wr, int_xoff_seen, int_rts_cts;
   logic        tx_push, fifo_enable, rts_n, dtr_n, sample_4x, irq_output_gate, dma_mode;
   logic        tx_break, stop_bits, sample_8x, baud_prescale_select, spare_output, loopback;
   logic        resume_any, infrared_mode;
   logic [2:0]  host_addr, parity_ctl;
   logic [7:0]  host_wdata, host_rdata, rx_char, line_status_in, tx_char, int_enable, v;
   logic [7:0]  resume_char_1, stop_char_1, resume_char_2, stop_char_2;
   logic [3:0]  int_source, modem_delta, modem_level, baud_fraction;
   logic [1:0]  word_length, tx_trigger, rx_trigger;
   logic [15:0] baud_divisor;
   int          err_count, n_compared;
   always #20 sys_clk = ~sys_clk;
   ucr_host_model host (.sys_clk, .host_cs, .host_addr, .host_rd, .host_wr, .host_wdata,
      .host_rdata);
   ucr_channel_regs dut (.sys_clk, .reset, .ce, .host_cs, .host_addr, .host_rd, .host_wr,
      .host_wdata, .host_rdata, .rx_char, .rx_pop(), .tx_char, .tx_push, .int_source,
      .int_xoff_seen, .int_rts_cts, .line_status_in, .modem_delta, .modem_level,
      .modem_status_read(), .fifo_enable, .rx_fifo_clr(), .tx_fifo_clr(), .dma_mode,
      .tx_trigger, .rx_trigger, .int_enable, .word_length, .stop_bits, .parity_ctl,
      .tx_break, .baud_divisor, .baud_fraction, .sample_8x, .sample_4x,
      .baud_prescale_select, .rts_n, .dtr_n, .irq_output_gate, .spare_output,
      .loopback, .resume_any, .infrared_mode, .soft_flow_mode(), .special_char_en(),
      .auto_rts_en(), .auto_cts_en(), .resume_char_1, .resume_char_2, .stop_char_1,
      .stop_char_2);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk(v, e);
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // watchdog far beyond the hundred or so cycles the sequence needs
   initial begin
      #100us;
      err_count++;
      give_verdict();
   end
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      ce = 1'b1;
      rx_char = 8'h3C;
      int_source = 4'h6;
      int_xoff_seen = 1'b0;
      int_rts_cts = 1'b0;
      line_status_in = 8'h61;
      modem_delta = 4'h5;
      modem_level = 4'hA;
      repeat (12) @(posedge sys_clk);
      #1 reset = 1'b0;
      rdc(3'h3, 8'h00);
      rdc(3'h1, 8'h00);
      host.wr(3'h7, 8'hA5);
      rdc(3'h7, 8'hA5);
      host.wr(3'h5, 8'h00);
      rdc(3'h5, 8'h61);
      rdc(3'h6, 8'hA5);
      rdc(3'h0, 8'h3C);
      host.wr(3'h0, 8'h5A);
      chk(tx_char, 8'h5A);
      host.wr(3'h2, 8'hFF);
      chk(fifo_enable, 1'b1);
      chk({dma_mode, rx_trigger, tx_trigger}, 5'h1C);
      rdc(3'h2, 8'hC6);
      host.wr(3'h1, 8'hFF);
      rdc(3'h1, 8'h0F);
      chk(int_enable, 8'h0F);
      host.wr(3'h3, 8'h83);
      host.wr(3'h0, 8'h34);
      host.wr(3'h1, 8'h12);
      chk(baud_divisor, 16'h1234);
      rdc(3'h0, 8'h34);
      host.wr(3'h2, 8'h3F);
      rdc(3'h2, 8'h00);
      host.wr(3'h3, 8'hBF);
      chk({tx_break, parity_ctl, stop_bits}, 5'h0F);
      host.wr(3'h2, 8'h10);
      rdc(3'h2, 8'h10);
      for (int i = 4; i < 8; i++) host.wr(i[2:0], 8'h11 * i[7:0]);
      for (int i = 4; i < 8; i++) rdc(i[2:0], 8'h11 * i[7:0]);
      chk(stop_char_1, 8'h66);
      host.wr(3'h3, 8'h00);
      chk(word_length, 2'b00);
      chk(stop_char_1, 8'h06);
      chk(resume_char_1, 8'h04);
      chk({resume_char_2, stop_char_2}, 16'h1517);
      int_xoff_seen = 1'b1;
      int_rts_cts = 1'b1;
      rdc(3'h2, 8'hF6);
      host.wr(3'h1, 8'hFF);
      rdc(3'h1, 8'hFF);
      host.wr(3'h4, 8'hEF);
      rdc(3'h4, 8'hEB);
      chk({rts_n, dtr_n, irq_output_gate}, 3'b001);
      chk({baud_prescale_select, infrared_mode, resume_any, loopback, spare_output},
         5'h1C);
      host.wr(3'h3, 8'h83);
      host.wr(3'h2, 8'h3F);
      rdc(3'h2, 8'h3F);
      chk({sample_8x, sample_4x, baud_fraction}, 6'h3F);
      host.wr(3'h3, 8'hBF);
      host.wr(3'h2, 8'h00);
      host.wr(3'h3, 8'h03);
      rdc(3'h1, 8'h0F);
      ce = 1'b0;
      host.wr(3'h7, 8'h5A);
      ce = 1'b1;
      rdc(3'h7, 8'hA5);
      // a second reset in mid-run must clear the control byte again
      reset = 1'b1;
      @(posedge sys_clk);
      #1 reset = 1'b0;
      rdc(3'h3, 8'h00);
      give_verdict();
   end
endmodule // uart_channel_register_decode_test
bind ucr_channel_regs ucr_channel_regs_properties chk_i (.sys_clk, .reset, .ce, .host_cs,
   .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata, .tx_char, .tx_push, .rx_pop,
   .rx_fifo_clr, .modem_status_read, .rts_n, .dtr_n);
